/* File: src/tsp_slot_map.sv */
// TDM slot placement map: register file, slot position, serial output.
// Assumes bit clock and frame sync arrive as pins, sampled by sys_clk
// which must run well above the bit clock rate.
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Field bits 4..0 of the slot register pick chip slot n+1 of 32.
// - The slot field resets to zero, so chip slot one is used.
// - Input width code 00 is 24 bits, 01 is 16 bits, 1x is 8 ignored.
// - Placements one, two, three are left one, right one, left two.
// - Sense codes 0..4 pick voltage, current, supply, gain, alt V/I.
// - Sense codes 5..8 pick status, marker, temperature and blank.
// - Placement one resets to 24-bit input and current, reading 0x01.
// - Placements two and three reset to unused input and current, 0x21.
// - A three-bit code sets 16, 24, 32, 48 or 64 clocks per slot.
// - Idle output cycles are high impedance or low per drive bit.
module tsp_slot_map
  import tsp_pkg::*;
#(
  parameter int FIFO_W = 26,
  parameter int FIFO_D = tsp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Settings held elsewhere
  input wire logic [2:0] clocks_per_chip_slot,
  input wire logic idle_cycle_drive,
  // Sense values
  input wire tsp_pkg::tsp_sense_t sense_in,
  input wire logic [7:0] limiter_gain_value,
  // Serial link pins
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  // Speaker words out
  output tsp_pkg::tsp_spk_t spk_data,
  output logic spk_valid,
  input wire logic spk_ready,
  output logic spk_overrun
);
  import tsp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Width functions
  // input width
  function automatic logic [5:0] in_bits(input logic [1:0] code);
    case (code)
      WID_24: in_bits = 6'd24;
      WID_16: in_bits = 6'd16;
      default: in_bits = 6'd8;
    endcase
  endfunction : in_bits

  function automatic logic [5:0] sns_bits(input logic [3:0] code);
    case (code)
      SNS_VOLT, SNS_CURR, SNS_ALT_VI: sns_bits = 6'd16;
      default: sns_bits = 6'd8;
    endcase
  endfunction : sns_bits

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [4:0] slot_ff;
  tsp_place_t place_ff [NUM_PLACE];
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;

  wire hit_slot = reg_addr == REG_SLOT_OFS;
  wire [NUM_PLACE-1:0] hit_pl;
  assign hit_pl[0] = reg_addr == REG_PL1_OFS;
  assign hit_pl[1] = reg_addr == REG_PL2_OFS;
  assign hit_pl[2] = reg_addr == REG_PL3_OFS;

  localparam logic [7:0] PL_RST [NUM_PLACE] = '{PL1_RST, PL2_RST, PL3_RST};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slot_ff <= SLOT_RST[SLOT_MSB:0];
    end else if (reg_wr && hit_slot) begin
      slot_ff <= reg_wdata[SLOT_MSB:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PLACE; gi++) begin : g_place
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          place_ff[gi] <= PL_RST[gi][WID_MSB:0];
        end else if (reg_wr && hit_pl[gi]) begin
          place_ff[gi] <= reg_wdata[WID_MSB:0];
        end
      end
    end
  endgenerate

  // Reserved bits read zero; unmapped reads zero
  wire [7:0] rd_mux =
    hit_slot ? {3'h0, slot_ff} :
    hit_pl[0] ? {2'h0, place_ff[0]} :
    hit_pl[1] ? {2'h0, place_ff[1]} :
    hit_pl[2] ? {2'h0, place_ff[2]} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : reg_rdata_ff;
      reg_rvalid_ff <= reg_rd;
    end
  end
  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] bclk_sync_ff;
  logic [1:0] fs_sync_ff;
  logic [1:0] din_sync_ff;
  logic bclk_last_ff;
  logic fs_last_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bclk_sync_ff <= 2'h0;
      fs_sync_ff <= 2'h0;
      din_sync_ff <= 2'h0;
      bclk_last_ff <= 1'b0;
      fs_last_ff <= 1'b0;
    end else begin
      bclk_sync_ff <= {bclk_sync_ff[0], bit_clk};
      fs_sync_ff <= {fs_sync_ff[0], frame_sync};
      din_sync_ff <= {din_sync_ff[0], serial_data_in};
      bclk_last_ff <= bclk_sync_ff[1];
      // Frame sync level as seen at the last bit clock rise
      fs_last_ff <= bclk_rise ? fs_sync_ff[1] : fs_last_ff;
    end
  end
  wire bclk_rise = bclk_sync_ff[1] && !bclk_last_ff;
  wire bclk_fall = !bclk_sync_ff[1] && bclk_last_ff;
  // A frame opens at the first rise that finds frame sync high; the
  // same test at a fall tells the driver that bit 0 comes next
  wire fs_start = fs_sync_ff[1] && !fs_last_ff;

  ////////////////////////////////////////////////////////////////////
  // Slot position
  // clocks per slot
  wire [6:0] slot_len =
    (clocks_per_chip_slot == 3'h0) ? 7'd16 :
    (clocks_per_chip_slot == 3'h1) ? 7'd24 :
    (clocks_per_chip_slot == 3'h3) ? 7'd48 :
    (clocks_per_chip_slot == 3'h4) ? 7'd64 : 7'd32;
  wire [11:0] slot_start = 12'(slot_ff) * 12'(slot_len);

  logic [11:0] bit_cnt_ff;
  logic in_frame_ff;
  // Position of the bit that this rise samples or this fall launches;
  // the counter lags one bit, so fall and rise agree on the position
  wire [11:0] bit_pos = fs_start ? 12'h000 : bit_cnt_ff + 12'h001;
  wire framed = in_frame_ff || fs_start;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bit_cnt_ff <= 12'h000;
      in_frame_ff <= 1'b0;
    end else if (bclk_rise) begin
      bit_cnt_ff <= bit_pos;
      in_frame_ff <= framed;
    end
  end
  wire [11:0] rel = bit_pos - slot_start;
  wire in_slot = framed && (bit_pos >= slot_start) &&
                 (rel < 12'(slot_len));

  wire [6:0] in_end0 = 7'(in_bits(place_ff[0].input_width));
  wire [6:0] in_end1 = in_end0 + 7'(in_bits(place_ff[1].input_width));
  wire [6:0] in_end2 = in_end1 + 7'(in_bits(place_ff[2].input_width));
  wire [6:0] sn_end0 = 7'(sns_bits(place_ff[0].sense_select));
  wire [6:0] sn_end1 = sn_end0 + 7'(sns_bits(place_ff[1].sense_select));
  wire [6:0] sn_end2 = sn_end1 + 7'(sns_bits(place_ff[2].sense_select));
  wire [6:0] r7 = rel[6:0];

  wire [1:0] in_pl = (r7 < in_end0) ? 2'd0 : (r7 < in_end1) ? 2'd1 :
                     (r7 < in_end2) ? 2'd2 : 2'd3;
  wire [1:0] sn_pl = (r7 < sn_end0) ? 2'd0 : (r7 < sn_end1) ? 2'd1 :
                     (r7 < sn_end2) ? 2'd2 : 2'd3;
  // Code 3 lies past the last placement; clamp it to keep reads in range
  wire [1:0] in_sel = (in_pl == 2'd3) ? 2'd2 : in_pl;
  wire [1:0] sn_sel = (sn_pl == 2'd3) ? 2'd2 : sn_pl;
  wire [6:0] sn_base = (sn_pl == 2'd0) ? 7'd0 :
                       (sn_pl == 2'd1) ? sn_end0 : sn_end1;
  wire in_last = in_slot && (in_pl != 2'd3) &&
                 (r7 == (in_pl == 2'd0 ? in_end0 :
                         in_pl == 2'd1 ? in_end1 : in_end2) - 7'd1);

  ////////////////////////////////////////////////////////////////////
  // Speaker word capture
  logic [23:0] shift_ff;
  tsp_spk_t push_data_ff;
  logic push_ff;
  logic overrun_ff;
  wire fifo_in_ready;
  wire [1:0] cur_wid = place_ff[in_sel].input_width;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_ff <= 24'h000000;
      push_ff <= 1'b0;
      push_data_ff <= '0;
      overrun_ff <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      if (bclk_rise && in_slot && in_pl != 2'd3) begin
        // Shifts through unused bits too; they are simply never pushed
        shift_ff <= {shift_ff[22:0], din_sync_ff[1]};
        if (in_last && !cur_wid[1]) begin
          push_ff <= 1'b1;
          push_data_ff.place <= in_pl;
          push_data_ff.word <= (cur_wid == WID_16) ?
            {shift_ff[14:0], din_sync_ff[1], 8'h00} :
            {shift_ff[22:0], din_sync_ff[1]};
        end
      end
      // Sticky until reset: software must learn that a word went missing
      if (push_ff && !fifo_in_ready) begin
        overrun_ff <= 1'b1;
      end
    end
  end
  assign spk_overrun = overrun_ff;

  tsp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_data(push_data_ff),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .out_data(spk_data),
    .out_valid(spk_valid),
    .out_ready(spk_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // Sense output
  logic alt_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alt_ff <= 1'b0;
    end else if (bclk_rise && fs_start) begin
      alt_ff <= !alt_ff;
    end
  end

  wire [3:0] cur_sns = place_ff[sn_sel].sense_select;
  wire [15:0] sns_word =
    (cur_sns == SNS_VOLT) ? sense_in.voltage :
    (cur_sns == SNS_CURR) ? sense_in.current :
    (cur_sns == SNS_SUPPLY) ? {sense_in.supply, 8'h00} :
    (cur_sns == SNS_GAIN) ? {limiter_gain_value, 8'h00} :
    (cur_sns == SNS_ALT_VI) ?
      (alt_ff ? sense_in.current : sense_in.voltage) :
    (cur_sns == SNS_STATUS) ? {sense_in.status, 8'h00} :
    (cur_sns == SNS_MARKER) ? {alt_ff, sense_in.status[6:0], 8'h00} :
    (cur_sns == SNS_TEMP) ? {sense_in.temp, 8'h00} : 16'h0000;
  wire [6:0] sn_idx = r7 - sn_base;
  wire sn_active = in_slot && (sn_pl != 2'd3);
  wire sn_bit = sns_word[4'(7'd15 - sn_idx)];

  logic sdo_ff;
  logic sdo_oe_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else if (bclk_fall) begin
      // Launched on the fall so the host's rise finds it settled
      sdo_ff <= sn_active ? sn_bit : 1'b0;
      sdo_oe_ff <= sn_active || idle_cycle_drive;
    end
  end
  assign serial_data_out = sdo_ff;
  assign serial_data_out_oe = sdo_oe_ff;
endmodule : tsp_slot_map
`default_nettype wire

/* File: common/tsp_pkg.sv */
// Package for the TDM slot placement map block.
// Assumes a single sys_clk domain; register port is a simple byte port.
`default_nettype none
package tsp_pkg;
  // Register offsets
  localparam logic [7:0] REG_SLOT_OFS = 8'h23;
  localparam logic [7:0] REG_PL1_OFS = 8'h24;
  localparam logic [7:0] REG_PL2_OFS = 8'h25;
  localparam logic [7:0] REG_PL3_OFS = 8'h26;
  // Reset values
  localparam logic [7:0] SLOT_RST = 8'h00;
  localparam logic [7:0] PL1_RST = 8'h01;
  localparam logic [7:0] PL2_RST = 8'h21;
  localparam logic [7:0] PL3_RST = 8'h21;
  // Field positions
  localparam int SLOT_MSB = 4;
  localparam int WID_MSB = 5;
  localparam int WID_LSB = 4;
  localparam int SNS_MSB = 3;
  // Sense codes
  localparam logic [3:0] SNS_VOLT = 4'h0;
  localparam logic [3:0] SNS_CURR = 4'h1;
  localparam logic [3:0] SNS_SUPPLY = 4'h2;
  localparam logic [3:0] SNS_GAIN = 4'h3;
  localparam logic [3:0] SNS_ALT_VI = 4'h4;
  localparam logic [3:0] SNS_STATUS = 4'h5;
  localparam logic [3:0] SNS_MARKER = 4'h6;
  localparam logic [3:0] SNS_TEMP = 4'h7;
  localparam logic [3:0] SNS_BLANK = 4'h8;
  // Input width codes
  localparam logic [1:0] WID_24 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  // Placement count and FIFO depth
  localparam int NUM_PLACE = 3;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic [1:0] input_width;
    logic [3:0] sense_select;
  } tsp_place_t;

  typedef struct packed {
    logic [15:0] voltage;
    logic [15:0] current;
    logic [7:0] supply;
    logic [7:0] gain;
    logic [7:0] status;
    logic [7:0] temp;
  } tsp_sense_t;

  typedef struct packed {
    logic [23:0] word;
    logic [1:0] place;
  } tsp_spk_t;
endpackage : tsp_pkg
`default_nettype wire

/* File: src/tsp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module tsp_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Write side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Read side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
              (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_wr);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_rd);
    end
  end
endmodule : tsp_fifo
`default_nettype wire

/* File: tb/tsp_host.sv */
// Host model: bus master of a 64-clock TDM frame.
// Assumes sys_clk; 16 sys_clk per bit clock, run seen at frame start.
`default_nettype none
module tsp_host (
  // Control
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [63:0] tx,
  // Link pins
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic bit_clk,
  output logic frame_sync,
  output logic sdi,
  // Capture, bit 0 of frame in bit 63
  output logic [63:0] rx,
  output logic [63:0] rx_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cnt_ff;
  logic [5:0] b;
  assign b = cnt_ff[9:4];
  initial {cnt_ff, bit_clk, frame_sync, sdi} = '0;
  // 64 clocks a frame, still between frames
  always @(posedge sys_clk) begin
    if (run || cnt_ff != 10'h0) begin
      cnt_ff <= cnt_ff + 10'h1;
      if (cnt_ff[3:0] == 4'h0) begin
        bit_clk <= 1'b0;
        frame_sync <= (b == 6'h0);
        sdi <= tx[63 - b];
      end
      if (cnt_ff[3:0] == 4'h8) begin
        bit_clk <= 1'b1;
        rx[63 - b] <= sdo;
        rx_oe[63 - b] <= sdo_oe;
      end
    end else begin
      bit_clk <= 1'b0;
      frame_sync <= 1'b0;
      // Released line toggles so stale bits never look valid
      sdi <= ~sdi;
    end
  end
endmodule : tsp_host
`default_nettype wire

/* File: tb/tsp_slot_map_sva.sv */
// Checker for the slot placement map, bound to its top ports.
// Assumes one clock domain and a synchronous reset.
`default_nettype none
module tsp_slot_map_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Link and speaker side
  input wire logic idle_cycle_drive,
  input wire logic serial_data_out_oe,
  input wire tsp_pkg::tsp_spk_t spk_data,
  input wire logic spk_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import tsp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  a_slot_field: assert property (
    reg_wr && reg_addr == 8'h23 ##1 reg_rd && !reg_wr && reg_addr == 8'h23
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f))
    else $error("slot field readback wrong");
  a_place_one: assert property (
    reg_wr && reg_addr == 8'h24 ##1 reg_rd && !reg_wr && reg_addr == 8'h24
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
    else $error("placement one readback wrong");
  a_place_three: assert property (
    reg_wr && reg_addr == 8'h26 ##1 reg_rd && !reg_wr && reg_addr == 8'h26
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
    else $error("placement three readback wrong");
  a_idle_release: assert property (
    $fell(serial_data_out_oe) |-> !idle_cycle_drive)
    else $error("output released while idle drive set");
  a_oe_after_reset: assert property (
    $fell(reset) |-> !serial_data_out_oe)
    else $error("output driven out of reset");
  a_place_range: assert property (
    spk_valid |-> spk_data.place != 2'h3)
    else $error("speaker word with no placement");
endmodule : tsp_slot_map_sva
bind tsp_slot_map tsp_slot_map_sva u_sva (.sys_clk, .reset, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .idle_cycle_drive,
  .serial_data_out_oe, .spk_data, .spk_valid);
`default_nettype wire

/* File: tb/test_tsp_slot_map.sv */
// Testbench for the slot placement map with a host model.
// Assumes FIFO depth shortened to 4 so overrun comes in two frames.
`default_nettype none
module test_tsp_slot_map;
  timeunit 1ns;
  timeprecision 1ns;
  import tsp_pkg::*;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, run = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, limiter_gain_value;
  logic reg_rvalid, idle_cycle_drive = 0, bit_clk, frame_sync;
  logic serial_data_in, serial_data_out, serial_data_out_oe;
  logic spk_valid, spk_ready = 0, spk_overrun;
  logic [2:0] clocks_per_chip_slot = 0;
  tsp_spk_t spk_data;
  tsp_sense_t sense_in;
  logic [63:0] tx = 0, rx, rx_oe;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  assign sense_in = {16'h8c31, 16'h4e72, 8'h96, 8'h3c, 8'ha5, 8'h5b};
  assign limiter_gain_value = 8'h3c;
  tsp_slot_map #(.FIFO_D(4)) uut (.sys_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .clocks_per_chip_slot,
    .idle_cycle_drive, .sense_in, .limiter_gain_value, .bit_clk,
    .frame_sync, .serial_data_in, .serial_data_out, .serial_data_out_oe,
    .spk_data, .spk_valid, .spk_ready, .spk_overrun);
  tsp_host host (.sys_clk, .run, .tx, .sdo(serial_data_out),
    .sdo_oe(serial_data_out_oe), .bit_clk, .frame_sync,
    .sdi(serial_data_in), .rx, .rx_oe);
  //////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [63:0] s, e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    // Answer stands only in the cycle after the request edge
    #1 chk("reg_rdata", {reg_rvalid, reg_rdata}, {1'b1, e});
    @(posedge sys_clk);
  endtask : rd
  // Write strobe held across the four mapped bytes
  task cfg(input logic [7:0] s, p1, p2, p3);
    logic [7:0] v [4];
    v = '{s, p1, p2, p3};
    reg_wr <= 1;
    for (int i = 0; i < 4; i++) begin
      reg_addr <= 8'h23 + i[7:0];
      reg_wdata <= v[i];
      @(posedge sys_clk);
    end
    reg_wr <= 0;
  endtask : cfg
  // Two frames; captures keep the second
  task frames(input logic [63:0] t);
    tx <= t;
    run <= 1;
    repeat (1100) @(posedge sys_clk);
    run <= 0;
    repeat (1100) @(posedge sys_clk);
  endtask : frames
  task pop(input logic [25:0] e);
    #1 chk("spk_data", {spk_valid, spk_data}, {1'b1, e});
    @(posedge sys_clk);
    spk_ready <= 1;
    @(posedge sys_clk);
    spk_ready <= 0;
  endtask : pop
  //////////////////////////////////////////////////////////////////////
  task t_reset_values;
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h01);
    rd(8'h25, 8'h21);
    rd(8'h26, 8'h21);
    rd(8'h40, 8'h00);
    chk("spk_overrun", spk_overrun, 0);
  endtask : t_reset_values
  task t_fields;
    wr(8'h23, 8'hff);
    rd(8'h23, 8'h1f);
    wr(8'h24, 8'hff);
    rd(8'h24, 8'h3f);
    for (int c = 0; c < 9; c++) begin
      wr(8'h26, 8'h20 | c[7:0]);
      rd(8'h26, 8'h20 | c[7:0]);
    end
  endtask : t_fields
  task t_second_slot;
    cfg(8'h01, 8'h10, 8'h22, 8'h27);
    clocks_per_chip_slot <= 3'h2;
    idle_cycle_drive <= 0;
    frames({32'h5a5ac3c3, 16'hb1e7, 16'h9669});
    chk("sdo", rx[31:0], {16'h8c31, 8'h96, 8'h5b});
    chk("oe", rx_oe, {32'h0, 32'hffffffff});
    pop({16'hb1e7, 8'h00, 2'h0});
    pop({16'hb1e7, 8'h00, 2'h0});
  endtask : t_second_slot
  task t_overrun;
    cfg(8'h00, 8'h11, 8'h15, 8'h08);
    clocks_per_chip_slot <= 3'h4;
    idle_cycle_drive <= 1;
    frames({16'h2d4b, 16'he190, 24'h7f0316, 8'h3e});
    chk("sdo", rx, {16'h4e72, 8'ha5, 40'h0});
    chk("oe", rx_oe, '1);
    chk("spk_overrun", spk_overrun, 1);
    pop({16'h2d4b, 8'h00, 2'h0});
    pop({16'he190, 8'h00, 2'h1});
    pop({24'h7f0316, 2'h2});
    pop({16'h2d4b, 8'h00, 2'h0});
    #1 chk("spk_valid", spk_valid, 0);
  endtask : t_overrun
  // Sixteen clocks a slot, fourth slot, gain and status, idle released
  task t_short_slot;
    cfg(8'h03, 8'h23, 8'h25, 8'h28);
    clocks_per_chip_slot <= 3'h0;
    idle_cycle_drive <= 0;
    frames(64'h0123456789abcdef);
    chk("sdo", rx[15:0], 16'h3ca5);
    chk("oe", rx_oe, {48'h0, 16'hffff});
    #1 chk("spk_valid", spk_valid, 0);
  endtask : t_short_slot
  task complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Hang guard well above the 7000 cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    t_reset_values;
    t_fields;
    t_second_slot;
    t_overrun;
    t_short_slot;
    @(posedge sys_clk);
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    t_reset_values;
    complete_run;
  end
endmodule : test_tsp_slot_map
`default_nettype wire
